// ---- rtl/wdtio_defs.svh ----
// constants for the port-mapped watchdog: offsets, fields, reset values, timing
`ifndef WDTIO_DEFS_SVH
`define WDTIO_DEFS_SVH

`define WDTIO_BASE_ADDR     16'h0600
`define WDTIO_OFS_ENABLE    16'h0047
`define WDTIO_OFS_UNIT      16'h0065
`define WDTIO_OFS_COUNT     16'h0066
`define WDTIO_OFS_STATUS    16'h0068

`define WDTIO_ENABLE_KEY    8'h0C
`define WDTIO_UNIT_SEC_BIT  7
`define WDTIO_STATUS_BIT    0

`define WDTIO_RST_ENABLE    8'h00
`define WDTIO_RST_UNIT      1'b0
`define WDTIO_RST_COUNT     8'h00
`define WDTIO_RST_STATUS    1'b0

`define WDTIO_CLK_MHZ       200
`define WDTIO_UNIT_MS       1000
`define WDTIO_SEC_CYCLES    (`WDTIO_UNIT_MS * 1000 * `WDTIO_CLK_MHZ)
`define WDTIO_SEC_PER_MIN   60

`endif

// ---- rtl/wdtio_pkg.sv ----
// types shared by the watchdog modules
package wdtio_pkg;

  typedef logic [7:0]  wdtio_byte_t;
  typedef logic [15:0] wdtio_addr_t;

  typedef enum logic [1:0] {
    WDTIO_OFF   = 2'b00,
    WDTIO_RUN   = 2'b01,
    WDTIO_FIRED = 2'b10
  } wdtio_state_t;

endpackage : wdtio_pkg

// ---- rtl/wdtio_timebase.sv ----
// second and minute tick generator for the watchdog countdown
`timescale 1ns/1ps
`default_nettype none
`include "wdtio_defs.svh"

module wdtio_timebase #(
  parameter int P_SEC_CYCLES = `WDTIO_SEC_CYCLES
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // control
  input  wire logic i_restart,
  // ticks
  output logic      o_sec_tick,
  output logic      o_min_tick
);
  import wdtio_pkg::*;

  logic [27:0] div_r;
  logic [5:0]  sec_r;
  logic        sec_end;
  logic        min_end;

  assign sec_end    = (div_r == 28'(P_SEC_CYCLES - 1));
  assign min_end    = (sec_r == 6'(`WDTIO_SEC_PER_MIN - 1));
  assign o_sec_tick = sec_end;
  assign o_min_tick = sec_end && min_end;

  // restart aligns a full unit to the moment of the refresh
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_restart || sec_end) begin
      div_r <= 28'h0000000;
    end else begin
      div_r <= div_r + 28'h0000001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_restart) begin
      sec_r <= 6'h00;
    end else if (sec_end) begin
      sec_r <= min_end ? 6'h00 : sec_r + 6'h01;
    end
  end

  a_sec_period : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_sec_tick |=> !o_sec_tick)
    else $error("second tick lasted more than one cycle");
  a_min_on_sec : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_min_tick |-> o_sec_tick && sec_r == 6'h3B)
    else $error("minute tick not on the sixtieth second");

endmodule : wdtio_timebase
`default_nettype wire

// ---- rtl/wdtio_top.sv ----
// port-mapped watchdog timer: byte i/o register block and countdown
`timescale 1ns/1ps
`default_nettype none
`include "wdtio_defs.svh"

module wdtio_top #(
  parameter int P_SEC_CYCLES = `WDTIO_SEC_CYCLES
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  // host byte i/o port
  input  wire wdtio_pkg::wdtio_addr_t i_io_addr,
  input  wire logic                 i_io_wr,
  input  wire logic                 i_io_rd,
  input  wire wdtio_pkg::wdtio_byte_t i_io_wdata,
  output wdtio_pkg::wdtio_byte_t    o_io_rdata,
  // watchdog result
  output logic                      o_wdt_expired
);
  import wdtio_pkg::*;

  wdtio_state_t state_r;
  wdtio_state_t state_nxt;
  wdtio_byte_t  enable_r;
  logic         unit_sec_r;
  wdtio_byte_t  timeout_r;
  wdtio_byte_t  cnt_r;
  logic         status_r;
  wdtio_byte_t  rdata_r;
  logic         sec_tick;
  logic         min_tick;
  logic         unit_tick;
  logic         armed;
  logic         fire;
  logic         hit_en;
  logic         hit_unit;
  logic         hit_cnt;
  logic         hit_stat;
  logic         wr_en;
  logic         wr_unit;
  logic         wr_cnt;
  logic         wr_stat;

  // address decode, full 16-bit match so aliases never hit
  assign hit_en   = (i_io_addr == (`WDTIO_BASE_ADDR + `WDTIO_OFS_ENABLE));
  assign hit_unit = (i_io_addr == (`WDTIO_BASE_ADDR + `WDTIO_OFS_UNIT));
  assign hit_cnt  = (i_io_addr == (`WDTIO_BASE_ADDR + `WDTIO_OFS_COUNT));
  assign hit_stat = (i_io_addr == (`WDTIO_BASE_ADDR + `WDTIO_OFS_STATUS));
  assign wr_en    = i_io_wr && hit_en;
  assign wr_unit  = i_io_wr && hit_unit;
  assign wr_cnt   = i_io_wr && hit_cnt;
  assign wr_stat  = i_io_wr && hit_stat;

  wdtio_timebase #(
    .P_SEC_CYCLES (P_SEC_CYCLES)
  ) u_timebase (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_restart  (wr_cnt || wr_unit),
    .o_sec_tick (sec_tick),
    .o_min_tick (min_tick)
  );

  assign unit_tick = unit_sec_r ? sec_tick : min_tick;
  assign armed     = (enable_r == `WDTIO_ENABLE_KEY);
  // a refresh in the same cycle as the last tick wins, so no expiry
  assign fire = armed && (state_r == WDTIO_RUN) && unit_tick
                && (cnt_r == 8'h01) && !wr_cnt;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      enable_r <= `WDTIO_RST_ENABLE;
    end else if (wr_en) begin
      enable_r <= i_io_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      unit_sec_r <= `WDTIO_RST_UNIT;
    end else if (wr_unit) begin
      unit_sec_r <= i_io_wdata[`WDTIO_UNIT_SEC_BIT];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      timeout_r <= `WDTIO_RST_COUNT;
    end else if (wr_cnt) begin
      timeout_r <= i_io_wdata;
    end
  end

  // remaining count; a write to the count register is the refresh
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_r <= `WDTIO_RST_COUNT;
    end else if (wr_cnt) begin
      cnt_r <= i_io_wdata;
    end else if (armed && state_r == WDTIO_RUN && unit_tick && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (!armed) begin
      state_nxt = WDTIO_OFF;
    end else if (wr_cnt) begin
      state_nxt = (i_io_wdata == 8'h00) ? WDTIO_OFF : WDTIO_RUN;
    end else begin
      unique case (state_r)
        WDTIO_OFF:   state_nxt = WDTIO_OFF;
        WDTIO_RUN:   state_nxt = fire ? WDTIO_FIRED : WDTIO_RUN;
        WDTIO_FIRED: state_nxt = WDTIO_FIRED;
        default:     state_nxt = WDTIO_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= WDTIO_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sticky flag, writing 1 clears it; a new expiry beats the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      status_r <= `WDTIO_RST_STATUS;
    end else if (fire) begin
      status_r <= 1'b1;
    end else if (wr_stat && i_io_wdata[`WDTIO_STATUS_BIT]) begin
      status_r <= 1'b0;
    end
  end

  // read data lands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
    end else if (i_io_rd) begin
      if (hit_en) begin
        rdata_r <= enable_r;
      end else if (hit_unit) begin
        rdata_r <= {unit_sec_r, 7'h00};
      end else if (hit_cnt) begin
        rdata_r <= timeout_r;
      end else if (hit_stat) begin
        rdata_r <= {7'h00, status_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign o_io_rdata    = rdata_r;
  assign o_wdt_expired = status_r;

  a_zero_disables : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_cnt && i_io_wdata == 8'h00 |=> state_r == WDTIO_OFF ##1 !fire)
    else $error("zero count did not disable the watchdog");
  a_refresh_reload : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_cnt |=> cnt_r == $past(i_io_wdata) && timeout_r == cnt_r)
    else $error("refresh did not reload the countdown");
  a_count_step : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_RUN && armed && unit_tick && cnt_r > 8'h01 && !wr_cnt
    |=> cnt_r == $past(cnt_r) - 8'h01 && state_r == WDTIO_RUN)
    else $error("countdown did not step by one unit");
  a_count_holds : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !unit_tick && !wr_cnt |=> $stable(cnt_r))
    else $error("count moved without a unit tick");
  a_expiry_flag : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    fire |=> status_r && o_wdt_expired && cnt_r == 8'h00 && state_r == WDTIO_FIRED)
    else $error("expiry did not set flag and output");
  a_flag_sticky : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    status_r && !(wr_stat && i_io_wdata[`WDTIO_STATUS_BIT]) |=> status_r)
    else $error("status flag dropped without a clear");
  a_unit_select : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_unit ##1 !wr_unit ##1 (!wr_unit && i_io_rd && hit_unit)
    |=> o_io_rdata == ($past(i_io_wdata, 3) & 8'h80))
    else $error("unit bit readback wrong");
  a_enable_gate : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !armed |=> state_r == WDTIO_OFF)
    else $error("watchdog ran without the enable key");

  // readback and hold checks: reserved bits stay zero, the flag matches the output, count freezes while disarmed, expiry holds
  a_reserved_zero : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_io_rd && hit_unit |=> o_io_rdata[6:0] == 7'h00)
    else $error("reserved unit bits read nonzero");
  a_status_read : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_io_rd && hit_stat |=> o_io_rdata == {7'h00, $past(o_wdt_expired)})
    else $error("status readback differs from expiry output");
  a_disarmed_frozen : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !armed && !wr_cnt |=> $stable(cnt_r) && !$rose(o_wdt_expired))
    else $error("count moved while the enable key was absent");
  a_fired_holds : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_FIRED && armed && !wr_cnt |=> state_r == WDTIO_FIRED && cnt_r == 8'h00)
    else $error("expired watchdog left its stopped state");

  c_expiry   : cover property (@(posedge i_clk_sys) disable iff (i_reset) fire);
  c_refresh  : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_RUN && wr_cnt && i_io_wdata != 8'h00);
  c_disable  : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_RUN && wr_cnt && i_io_wdata == 8'h00);
  c_min_step : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_RUN && !unit_sec_r && min_tick);
  c_refresh_race : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == WDTIO_RUN && wr_cnt && unit_tick && cnt_r == 8'h01);

endmodule : wdtio_top
`default_nettype wire

// ---- verif/wdtio_bench.sv ----
// self-checking bench for the port-mapped watchdog, with a register model
`timescale 1ns/1ps
`default_nettype none
`include "wdtio_defs.svh"
module wdtio_bench;
  import wdtio_pkg::*;
  localparam int P = 4;
  logic        i_clk_sys;
  logic        i_reset;
  logic        i_io_wr;
  logic        i_io_rd;
  logic        o_wdt_expired;
  wdtio_addr_t i_io_addr;
  wdtio_byte_t i_io_wdata;
  wdtio_byte_t o_io_rdata;
  int          failures = 0;
  int          checks = 0;
  int          seed = 15;
  int          n;
  int          mdl[int];
  wdtio_top #(.P_SEC_CYCLES(P)) uut (
    .i_clk_sys     (i_clk_sys),
    .i_reset       (i_reset),
    .i_io_addr     (i_io_addr),
    .i_io_wr       (i_io_wr),
    .i_io_rd       (i_io_rd),
    .i_io_wdata    (i_io_wdata),
    .o_io_rdata    (o_io_rdata),
    .o_wdt_expired (o_wdt_expired)
  );
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // returns at the falling edge just after the write edge
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_io_addr  = `WDTIO_BASE_ADDR + 16'(ofs);
    i_io_wdata = d;
    i_io_wr    = 1'b1;
    @(negedge i_clk_sys);
    i_io_wr = 1'b0;
    if (ofs == 8'h65)
      mdl[ofs] = d & 8'h80;
    else if (ofs == 8'h68)
      mdl[ofs] = d[0] ? 0 : mdl[ofs];
    else if (mdl.exists(ofs))
      mdl[ofs] = d;
  endtask : wr
  task automatic rd(input logic [7:0] ofs);
    @(negedge i_clk_sys);
    i_io_addr = `WDTIO_BASE_ADDR + 16'(ofs);
    i_io_rd   = 1'b1;
    @(negedge i_clk_sys);
    i_io_rd = 1'b0;
    @(negedge i_clk_sys);
    check(o_io_rdata, mdl.exists(ofs) ? 8'(mdl[ofs]) : 8'h00);
  endtask : rd
  // bounded watch after a count write; expiry due in cycle due, 0 means never
  task automatic run(input int cyc, input int due);
    for (int i = 1; i <= cyc; i++) begin
      @(negedge i_clk_sys);
      check({7'h00, o_wdt_expired}, {7'h00, due != 0 && i >= due});
    end
    if (due != 0)
      mdl[8'h68] = 1;
  endtask : run
  initial begin
    #50us;
    failures++;
    test_done();
  end
  initial begin
    i_reset = 1'b1;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    i_io_addr = 16'h0000;
    i_io_wdata = 8'h00;
    mdl[8'h47] = 0;
    mdl[8'h65] = 0;
    mdl[8'h66] = 0;
    mdl[8'h68] = 0;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    foreach (mdl[k]) rd(k[7:0]);
    wr(8'h67, 8'hFF);
    rd(8'h67);
    wr(8'h66, 8'h03);
    run(20, 0);
    $display("reset and decode test done");
    wr(8'h47, 8'h0C);
    wr(8'h65, 8'hFF);
    rd(8'h65);
    for (int k = 0; k < 3; k++) begin
      n = 1 + ($random(seed) & 3);
      wr(8'h66, n[7:0]);
      run(n * P + 3, n * P);
      rd(8'h66);
      rd(8'h68);
      wr(8'h68, 8'h01);
      rd(8'h68);
      run(1, 0);
    end
    $display("second countdown test done");
    wr(8'h66, 8'h02);
    run(6, 0);
    wr(8'h66, 8'h02);
    run(10, 8);
    wr(8'h68, 8'h01);
    $display("refresh test done");
    wr(8'h66, 8'h05);
    run(10, 0);
    wr(8'h66, 8'h00);
    run(30, 0);
    rd(8'h66);
    $display("zero count test done");
    wr(8'h66, 8'hFF);
    run(1025, 255 * P);
    wr(8'h68, 8'h01);
    wr(8'h65, 8'h00);
    wr(8'h66, 8'h01);
    run(245, 60 * P);
    wr(8'h68, 8'h01);
    $display("range and minute test done");
    wr(8'h47, 8'h0D);
    wr(8'h66, 8'h01);
    run(300, 0);
    rd(8'h47);
    $display("enable key test done");
    test_done();
  end
endmodule : wdtio_bench
`default_nettype wire
